/* core/modulator_pkg.sv */
package modulator_pkg;

    // ==================================================================
    // register map, byte addresses on the 32-bit bus
    localparam logic [7:0] CONTROL_OFFSET      = 8'h00;
    localparam logic [7:0] DATA_SOURCE_OFFSET  = 8'h04;
    localparam logic [7:0] HIGH_CARRIER_OFFSET = 8'h08;
    localparam logic [7:0] LOW_CARRIER_OFFSET  = 8'h0c;

    // ==================================================================
    // modulation_control bit positions
    localparam int MODULE_ON_BIT     = 7;
    localparam int PIN_OE_BIT        = 6;
    localparam int SLEW_LIMIT_BIT    = 5;
    localparam int OUTPUT_INVERT_BIT = 4;
    localparam int KEYED_STATUS_BIT  = 3;
    localparam int SOFT_DATA_BIT     = 0;

    // ==================================================================
    // source and carrier register bit positions
    localparam int PIN_DETACH_BIT    = 7;
    localparam int CARRIER_INV_BIT   = 6;
    localparam int CARRIER_SYNC_BIT  = 5;
    localparam int SELECT_LSB        = 0;
    localparam int SELECT_WIDTH      = 4;

    // ==================================================================
    // values after reset
    localparam logic [7:0] CONTROL_RESET      = 8'h20;
    localparam logic [7:0] DATA_SOURCE_RESET  = 8'h00;
    localparam logic [7:0] CARRIER_REG_RESET  = 8'h00;

    // ==================================================================
    // data stream select codes
    localparam logic [3:0] DSEL_SOFT_BIT   = 4'h0;
    localparam logic [3:0] DSEL_INPUT_PIN  = 4'h1;
    localparam logic [3:0] DSEL_PWM_ONE    = 4'h2;
    localparam logic [3:0] DSEL_PWM_TWO    = 4'h3;
    localparam logic [3:0] DSEL_PWM_THREE  = 4'h4;
    localparam logic [3:0] DSEL_PWM_FOUR   = 4'h5;
    localparam logic [3:0] DSEL_COMP_ONE   = 4'h6;
    localparam logic [3:0] DSEL_COMP_TWO   = 4'h7;
    localparam logic [3:0] DSEL_SPI_ONE    = 4'h8;
    localparam logic [3:0] DSEL_SPI_TWO    = 4'h9;
    localparam logic [3:0] DSEL_UART_TX    = 4'ha;

    // ==================================================================
    // carrier select codes
    localparam logic [3:0] CSEL_GROUND     = 4'h0;
    localparam logic [3:0] CSEL_PIN_A      = 4'h1;
    localparam logic [3:0] CSEL_PIN_B      = 4'h2;
    localparam logic [3:0] CSEL_REF_CLOCK  = 4'h3;
    localparam logic [3:0] CSEL_PWM_ONE    = 4'h4;
    localparam logic [3:0] CSEL_PWM_TWO    = 4'h5;
    localparam logic [3:0] CSEL_PWM_THREE  = 4'h6;
    localparam logic [3:0] CSEL_PWM_FOUR   = 4'h7;

    // ==================================================================
    // types
    typedef struct packed {
        logic       pin_detach;
        logic       invert;
        logic       sync;
        logic [3:0] select;
    } carrier_cfg_type;

    typedef struct packed {
        logic [3:0] capture_pwm;
        logic [1:0] comparator;
        logic [1:0] spi_data;
        logic       uart_tx;
        logic       data_input_pin;
        logic       carrier_input_pin_a;
        logic       carrier_input_pin_b;
        logic       ref_clock;
    } source_bus_type;

endpackage

/* core/sync_cell.sv */
`timescale 1ns/100ps
module sync_cell #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // level in and synchronised level out
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] stage_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stage_q <= '0;
            sync_o  <= '0;
        end else begin
            stage_q <= async_i;
            sync_o  <= stage_q;
        end
    end

endmodule // sync_cell

/* core/data_signal_modulator.sv */
// Register access over Wishbone and the address map are this design's own decisions.
`timescale 1ns/100ps
module data_signal_modulator (
    // clock and reset
    input  wire logic                         clk_i,
    input  wire logic                         rst_i,
    // wishbone slave
    input  wire logic                         cyc_i,
    input  wire logic                         stb_i,
    input  wire logic                         we_i,
    input  wire logic [7:0]                   adr_i,
    input  wire logic [3:0]                   sel_i,
    input  wire logic [31:0]                  dat_i,
    output logic      [31:0]                  dat_o,
    output logic                              ack_o,
    // signal sources
    input  wire modulator_pkg::source_bus_type sources_i,
    // keyed output pad
    output logic                              keyed_output_o,
    output logic                              output_slew_limit_o,
    // pin detach flags, one bit per select code
    output logic      [15:0]                  data_source_pin_detach_o,
    output logic      [15:0]                  high_carrier_pin_detach_o,
    output logic      [15:0]                  low_carrier_pin_detach_o
);

    import modulator_pkg::*;

    // ==================================================================
    // registers
    logic            module_on_q;
    logic            pin_output_enable_q;
    logic            output_slew_limit_q;
    logic            output_invert_q;
    logic            software_data_bit_q;
    logic            data_source_pin_detach_q;
    logic [3:0]      data_source_select_q;
    carrier_cfg_type high_carrier_q;
    carrier_cfg_type low_carrier_q;

    // ==================================================================
    // bus signals
    logic            req;
    logic            wr_ctrl;
    logic            wr_src;
    logic            wr_high;
    logic            wr_low;
    logic [7:0]      wbyte;
    logic [7:0]      rd_byte;
    logic            ack_q;
    logic            keyed_status;

    // ==================================================================
    // mixer signals
    logic [3:0]      data_sel_eff;
    logic [3:0]      high_sel_eff;
    logic [3:0]      low_sel_eff;
    logic            data_stream;
    logic            high_carrier_signal;
    logic            low_carrier_signal;
    logic            use_high;
    logic            use_high_q;
    logic            active_sync;
    logic            active_level;
    logic            mixed;
    logic            pin_level;

    // ==================================================================
    // source multiplexers
    function automatic logic pick_data(input logic [3:0] code,
                                       input source_bus_type s,
                                       input logic soft_bit);
        logic v;
        v = 1'b0;
        if (code == DSEL_SOFT_BIT) begin
            v = soft_bit;
        end else if (code == DSEL_INPUT_PIN) begin
            v = s.data_input_pin;
        end else if (code == DSEL_PWM_ONE) begin
            v = s.capture_pwm[0];
        end else if (code == DSEL_PWM_TWO) begin
            v = s.capture_pwm[1];
        end else if (code == DSEL_PWM_THREE) begin
            v = s.capture_pwm[2];
        end else if (code == DSEL_PWM_FOUR) begin
            v = s.capture_pwm[3];
        end else if (code == DSEL_COMP_ONE) begin
            v = s.comparator[0];
        end else if (code == DSEL_COMP_TWO) begin
            v = s.comparator[1];
        end else if (code == DSEL_SPI_ONE) begin
            v = s.spi_data[0];
        end else if (code == DSEL_SPI_TWO) begin
            v = s.spi_data[1];
        end else if (code == DSEL_UART_TX) begin
            v = s.uart_tx;
        end
        return v;
    endfunction

    function automatic logic pick_carrier(input logic [3:0] code,
                                          input source_bus_type s);
        logic v;
        v = 1'b0;
        // carrier code decode, unused codes give zero
        if (code == CSEL_PIN_A) begin
            v = s.carrier_input_pin_a;
        end else if (code == CSEL_PIN_B) begin
            v = s.carrier_input_pin_b;
        end else if (code == CSEL_REF_CLOCK) begin
            v = s.ref_clock;
        end else if (code == CSEL_PWM_ONE) begin
            v = s.capture_pwm[0];
        end else if (code == CSEL_PWM_TWO) begin
            v = s.capture_pwm[1];
        end else if (code == CSEL_PWM_THREE) begin
            v = s.capture_pwm[2];
        end else if (code == CSEL_PWM_FOUR) begin
            v = s.capture_pwm[3];
        end
        return v;
    endfunction

    // ==================================================================
    // effective selections
    // off forces ground and soft bit
    assign data_sel_eff = module_on_q ? data_source_select_q : DSEL_SOFT_BIT;
    assign high_sel_eff = module_on_q ? high_carrier_q.select : CSEL_GROUND;
    assign low_sel_eff  = module_on_q ? low_carrier_q.select  : CSEL_GROUND;

    assign data_stream = pick_data(data_sel_eff, sources_i, software_data_bit_q);

    assign high_carrier_signal = pick_carrier(high_sel_eff, sources_i)
                                 ^ (module_on_q & high_carrier_q.invert);
    assign low_carrier_signal  = pick_carrier(low_sel_eff, sources_i)
                                 ^ (module_on_q & low_carrier_q.invert);

    // ==================================================================
    // carrier switch synchronisation
    assign active_sync  = use_high_q ? high_carrier_q.sync : low_carrier_q.sync;
    assign active_level = use_high_q ? high_carrier_signal : low_carrier_signal;

    always_comb begin
        use_high = data_stream;
        // hold carrier while its pulse is high
        if (module_on_q && active_sync && active_level &&
            (data_stream != use_high_q)) begin
            use_high = use_high_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            use_high_q <= 1'b0;
        end else begin
            use_high_q <= use_high;
        end
    end

    // ==================================================================
    // mixer and output stage
    // carrier chosen by data stream
    assign mixed = use_high ? high_carrier_signal : low_carrier_signal;

    // pin held low when not enabled
    assign pin_level = module_on_q & pin_output_enable_q & (mixed ^ output_invert_q);

    assign keyed_output_o = pin_level;

    assign output_slew_limit_o = output_slew_limit_q;

    sync_cell #(
        .WIDTH (1)
    ) status_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i (pin_level),
        .sync_o  (keyed_status)
    );

    // ==================================================================
    // pin detach flags
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            data_source_pin_detach_o  <= 16'h0000;
            high_carrier_pin_detach_o <= 16'h0000;
            low_carrier_pin_detach_o  <= 16'h0000;
        end else begin
            data_source_pin_detach_o  <= data_source_pin_detach_q ?
                                         (16'h0001 << data_sel_eff) : 16'h0000;
            high_carrier_pin_detach_o <= high_carrier_q.pin_detach ?
                                         (16'h0001 << high_sel_eff) : 16'h0000;
            low_carrier_pin_detach_o  <= low_carrier_q.pin_detach ?
                                         (16'h0001 << low_sel_eff) : 16'h0000;
        end
    end

    // ==================================================================
    // wishbone decode
    assign req   = cyc_i & stb_i & ~ack_q;
    assign wbyte = dat_i[7:0];

    always_comb begin
        wr_ctrl = 1'b0;
        wr_src  = 1'b0;
        wr_high = 1'b0;
        wr_low  = 1'b0;
        if (req && we_i && sel_i[0]) begin
            if (adr_i == CONTROL_OFFSET) begin
                wr_ctrl = 1'b1;
            end else if (adr_i == DATA_SOURCE_OFFSET) begin
                wr_src = 1'b1;
            end else if (adr_i == HIGH_CARRIER_OFFSET) begin
                wr_high = 1'b1;
            end else if (adr_i == LOW_CARRIER_OFFSET) begin
                wr_low = 1'b1;
            end
        end
    end

    always_comb begin
        rd_byte = 8'h00;
        if (adr_i == CONTROL_OFFSET) begin
            // bits 2 to 1 read zero
            rd_byte[MODULE_ON_BIT]     = module_on_q;
            rd_byte[PIN_OE_BIT]        = pin_output_enable_q;
            rd_byte[SLEW_LIMIT_BIT]    = output_slew_limit_q;
            rd_byte[OUTPUT_INVERT_BIT] = output_invert_q;
            rd_byte[KEYED_STATUS_BIT]  = keyed_status;
            rd_byte[SOFT_DATA_BIT]     = software_data_bit_q;
        end else if (adr_i == DATA_SOURCE_OFFSET) begin
            rd_byte[PIN_DETACH_BIT]    = data_source_pin_detach_q;
            rd_byte[3:0]               = data_source_select_q;
        end else if (adr_i == HIGH_CARRIER_OFFSET) begin
            rd_byte = {high_carrier_q.pin_detach, high_carrier_q.invert,
                       high_carrier_q.sync, 1'b0, high_carrier_q.select};
        end else if (adr_i == LOW_CARRIER_OFFSET) begin
            rd_byte = {low_carrier_q.pin_detach, low_carrier_q.invert,
                       low_carrier_q.sync, 1'b0, low_carrier_q.select};
        end
    end

    // ==================================================================
    // bus answer, one-cycle ack, unmapped reads zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_q <= req;
            if (req && !we_i) begin
                dat_o <= {24'h000000, rd_byte};
            end
        end
    end

    assign ack_o = ack_q;

    // ==================================================================
    // control register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            module_on_q         <= CONTROL_RESET[MODULE_ON_BIT];
            pin_output_enable_q <= CONTROL_RESET[PIN_OE_BIT];
            output_slew_limit_q <= CONTROL_RESET[SLEW_LIMIT_BIT];
            output_invert_q     <= CONTROL_RESET[OUTPUT_INVERT_BIT];
            software_data_bit_q <= CONTROL_RESET[SOFT_DATA_BIT];
        end else if (wr_ctrl) begin
            // status and bits 2 to 1 not written
            module_on_q         <= wbyte[MODULE_ON_BIT];
            pin_output_enable_q <= wbyte[PIN_OE_BIT];
            output_slew_limit_q <= wbyte[SLEW_LIMIT_BIT];
            output_invert_q     <= wbyte[OUTPUT_INVERT_BIT];
            software_data_bit_q <= wbyte[SOFT_DATA_BIT];
        end
    end

    // ==================================================================
    // data source register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            data_source_pin_detach_q <= DATA_SOURCE_RESET[PIN_DETACH_BIT];
            data_source_select_q     <= DATA_SOURCE_RESET[3:0];
        end else if (wr_src) begin
            data_source_pin_detach_q <= wbyte[PIN_DETACH_BIT];
            data_source_select_q     <= wbyte[3:0];
        end
    end

    // ==================================================================
    // carrier registers
    // separate high and low selects
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            high_carrier_q <= '{pin_detach: CARRIER_REG_RESET[PIN_DETACH_BIT],
                                invert:     CARRIER_REG_RESET[CARRIER_INV_BIT],
                                sync:       CARRIER_REG_RESET[CARRIER_SYNC_BIT],
                                select:     CARRIER_REG_RESET[3:0]};
        end else if (wr_high) begin
            high_carrier_q <= '{pin_detach: wbyte[PIN_DETACH_BIT],
                                invert:     wbyte[CARRIER_INV_BIT],
                                sync:       wbyte[CARRIER_SYNC_BIT],
                                select:     wbyte[3:0]};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            low_carrier_q <= '{pin_detach: CARRIER_REG_RESET[PIN_DETACH_BIT],
                               invert:     CARRIER_REG_RESET[CARRIER_INV_BIT],
                               sync:       CARRIER_REG_RESET[CARRIER_SYNC_BIT],
                               select:     CARRIER_REG_RESET[3:0]};
        end else if (wr_low) begin
            low_carrier_q <= '{pin_detach: wbyte[PIN_DETACH_BIT],
                               invert:     wbyte[CARRIER_INV_BIT],
                               sync:       wbyte[CARRIER_SYNC_BIT],
                               select:     wbyte[3:0]};
        end
    end

endmodule // data_signal_modulator

/* dv/modulator_assertions.sv */
`timescale 1ns/100ps
module modulator_assertions (
    // clock, reset and bus
    input wire logic                          clk_i,
    input wire logic                          rst_i,
    input wire logic                          cyc_i,
    input wire logic                          stb_i,
    input wire logic                          we_i,
    input wire logic [7:0]                    adr_i,
    input wire logic [3:0]                    sel_i,
    input wire logic [31:0]                   dat_i,
    input wire logic [31:0]                   dat_o,
    input wire logic                          ack_o,
    // sources and pad
    input wire modulator_pkg::source_bus_type sources_i,
    input wire logic                          keyed_output_o,
    input wire logic                          output_slew_limit_o,
    input wire logic [15:0]                   data_source_pin_detach_o,
    input wire logic [15:0]                   high_carrier_pin_detach_o,
    input wire logic [15:0]                   low_carrier_pin_detach_o
);
    import modulator_pkg::*;
    logic       take;
    logic [7:0] ctrl_q;
    assign take = cyc_i && stb_i && !ack_o;
    // shadow of the control register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= CONTROL_RESET;
        end else if (take && we_i && sel_i[0] && adr_i == CONTROL_OFFSET) begin
            ctrl_q <= dat_i[7:0];
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_answers: assert property (take |=> ack_o)
        else $error("no ack after request");
    a_ack_single: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    a_slew_tracks: assert property (output_slew_limit_o == ctrl_q[SLEW_LIMIT_BIT])
        else $error("slew output differs from control");
    a_off_pin_low: assert property (!ctrl_q[MODULE_ON_BIT] |-> !keyed_output_o)
        else $error("pin active while module off");
    a_oe_pin_low: assert property (!ctrl_q[PIN_OE_BIT] |-> !keyed_output_o)
        else $error("pin active while output disabled");
    a_ctrl_read: assert property (ack_o && !we_i && adr_i == CONTROL_OFFSET |->
        dat_o[2:1] == 2'h0 && dat_o[31:8] == 24'h0 && dat_o[7:4] == ctrl_q[7:4])
        else $error("control read value wrong");
    a_reset_defaults: assert property ($fell(rst_i) |-> output_slew_limit_o && !ack_o)
        else $error("defaults wrong after reset");
    a_off_ground: assert property (!ctrl_q[7] ##1 !ctrl_q[7] |->
        high_carrier_pin_detach_o[15:1] == 15'h0 && low_carrier_pin_detach_o[15:1] == 15'h0)
        else $error("carrier not grounded while off");
    c_write: cover property (take && we_i);
    c_keyed_rise: cover property ($rose(keyed_output_o));
    c_detach: cover property (data_source_pin_detach_o != 16'h0);
endmodule // modulator_assertions

bind data_signal_modulator modulator_assertions chk_u (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .sources_i(sources_i),
    .keyed_output_o(keyed_output_o), .output_slew_limit_o(output_slew_limit_o),
    .data_source_pin_detach_o(data_source_pin_detach_o),
    .high_carrier_pin_detach_o(high_carrier_pin_detach_o),
    .low_carrier_pin_detach_o(low_carrier_pin_detach_o));

/* dv/source_model.sv */
`timescale 1ns/100ps
module source_model (
    // clock
    input  wire logic                     clk_i,
    // levels and reference run request
    input  wire logic [12:0]              level_i,
    input  wire logic                     ref_run_i,
    // sources seen by the modulator
    output modulator_pkg::source_bus_type sources_o
);
    import modulator_pkg::*;
    logic [1:0] div_q;
    logic       ref_q;
    always_ff @(posedge clk_i) begin
        if (!ref_run_i) begin
            div_q <= 2'h0;
            ref_q <= 1'b0;
        end else if (div_q == 2'h2) begin
            div_q <= 2'h0;
            ref_q <= ~ref_q;
        end else begin
            div_q <= div_q + 2'h1;
        end
    end
    assign sources_o = {level_i[12:1], ref_run_i ? ref_q : level_i[0]};
endmodule // source_model

/* dv/data_signal_modulator_tb.sv */
`timescale 1ns/100ps
module data_signal_modulator_tb;
    import modulator_pkg::*;
    localparam int DMAP [16] = '{0, 3, 9, 10, 11, 12, 7, 8, 5, 6, 4, 0, 0, 0, 0, 0};
    logic           clk_i = 1'b0;
    logic           rst_i = 1'b1;
    logic           cyc = 1'b0;
    logic           stb = 1'b0;
    logic           we = 1'b0;
    logic [3:0]     sel = 4'h0;
    logic [7:0]     adr = 8'h00;
    logic [31:0]    wdat = 32'h0;
    logic [12:0]    level = 13'h0;
    logic           ref_run = 1'b0;
    logic [31:0]    rdat, got_q;
    logic           ack, keyed, slew;
    logic [15:0]    det_d, det_h, det_l;
    source_bus_type src;
    int             mismatches = 0;
    int             checks_done = 0;

    always #50 clk_i = ~clk_i;

    source_model model_u (.clk_i(clk_i), .level_i(level), .ref_run_i(ref_run), .sources_o(src));
    data_signal_modulator dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .sources_i(src),
        .keyed_output_o(keyed), .output_slew_limit_o(slew), .data_source_pin_detach_o(det_d),
        .high_carrier_pin_detach_o(det_h), .low_carrier_pin_detach_o(det_l));

    // ==================================================================
    // helpers
    task close_out;
        if (mismatches == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task cmp_bit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %0t bit %b expected %b", $time, got, exp);
        end
    endtask
    task cmp_word(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %0t word %h expected %h", $time, got, exp);
        end
    endtask
    task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'hf;
        adr <= a;
        wdat <= {24'h0, d};
        do @(posedge clk_i); while (ack !== 1'b1);
        got_q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        sel <= 4'h0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] exp);
        wb(1'b0, a, 8'h00);
        cmp_word(got_q, {24'h0, exp});
    endtask
    task settle;
        @(posedge clk_i);
        #10;
    endtask
    task chk(input logic exp);
        settle;
        cmp_bit(keyed, exp);
    endtask

    // ==================================================================
    // scenarios
    task t_reset;
        rd(CONTROL_OFFSET, CONTROL_RESET);
        rd(DATA_SOURCE_OFFSET, 8'h00);
        rd(HIGH_CARRIER_OFFSET, 8'h00);
        rd(LOW_CARRIER_OFFSET, 8'h00);
        wb(1'b1, 8'h10, 8'hff);
        rd(8'h10, 8'h00);
        rd(CONTROL_OFFSET, CONTROL_RESET);
        cmp_bit(slew, 1'b1);
        wb(1'b1, CONTROL_OFFSET, 8'hff);
        rd(CONTROL_OFFSET, 8'hf9);
        cmp_bit(keyed, 1'b1);
        wb(1'b1, CONTROL_OFFSET, 8'hd1);
        settle;
        cmp_bit(slew, 1'b0);
    endtask
    task t_data;
        wb(1'b1, HIGH_CARRIER_OFFSET, {4'h0, CSEL_PIN_A});
        wb(1'b1, LOW_CARRIER_OFFSET, {4'h0, CSEL_GROUND});
        wb(1'b1, CONTROL_OFFSET, 8'hc0);
        for (int c = 1; c < 16; c++) begin
            wb(1'b1, DATA_SOURCE_OFFSET, 8'h80 | c[7:0]);
            level <= (c > 10) ? 13'h1ffc : (13'h0004 | (13'h1 << DMAP[c]));
            chk(c <= 10);
            if (c <= 10) cmp_word({16'h0, det_d}, 32'h1 << c);
            @(posedge clk_i);
            level <= 13'h0004;
            chk(1'b0);
        end
    endtask
    task t_carrier;
        logic [7:0] a;
        wb(1'b1, DATA_SOURCE_OFFSET, {4'h0, DSEL_SOFT_BIT});
        level <= 13'h1e07;
        for (int s = 0; s < 2; s++) begin
            a = s ? HIGH_CARRIER_OFFSET : LOW_CARRIER_OFFSET;
            wb(1'b1, CONTROL_OFFSET, 8'hc0 | s[7:0]);
            wb(1'b1, s ? LOW_CARRIER_OFFSET : HIGH_CARRIER_OFFSET, 8'h00);
            for (int c = 0; c < 16; c++) begin
                wb(1'b1, a, c[7:0]);
                chk(c >= 1 && c <= 7);
                wb(1'b1, a, 8'h40 | c[7:0]);
                chk(c < 1 || c > 7);
                wb(1'b1, a, 8'h80 | c[7:0]);
                settle;
                if (c <= 7) cmp_word({16'h0, s ? det_h : det_l}, 32'h1 << c);
            end
        end
    endtask
    task t_off;
        wb(1'b1, DATA_SOURCE_OFFSET, {4'h0, DSEL_INPUT_PIN});
        wb(1'b1, HIGH_CARRIER_OFFSET, {4'h0, CSEL_PIN_A});
        level <= 13'h000c;
        wb(1'b1, CONTROL_OFFSET, 8'hc0);
        chk(1'b1);
        wb(1'b1, CONTROL_OFFSET, 8'h40);
        chk(1'b0);
        rd(HIGH_CARRIER_OFFSET, {4'h0, CSEL_PIN_A});
        wb(1'b1, CONTROL_OFFSET, 8'h80);
        chk(1'b0);
        wb(1'b1, CONTROL_OFFSET, 8'hc0);
        chk(1'b1);
    endtask
    task t_sync(input logic on, input logic exp);
        wb(1'b1, HIGH_CARRIER_OFFSET, on ? 8'h23 : 8'h03);
        level <= 13'h0008;
        ref_run <= 1'b1;
        do @(posedge clk_i); while (src.ref_clock !== 1'b0);
        do @(posedge clk_i); while (src.ref_clock !== 1'b1);
        level <= 13'h0000;
        chk(exp);
        repeat (4) @(posedge clk_i);
        chk(1'b0);
        @(posedge clk_i);
        ref_run <= 1'b0;
    endtask
    task t_rereset;
        wb(1'b1, CONTROL_OFFSET, 8'h51);
        wb(1'b1, HIGH_CARRIER_OFFSET, 8'h83);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(CONTROL_OFFSET, CONTROL_RESET);
        cmp_word({16'h0, det_h}, 32'h0);
    endtask

    initial begin
        repeat (30000) @(posedge clk_i);
        mismatches++;
        close_out;
    end
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset;
        t_data;
        t_carrier;
        t_off;
        t_sync(1'b1, 1'b1);
        t_sync(1'b0, 1'b0);
        t_rereset;
        close_out;
    end
endmodule // data_signal_modulator_tb
